// file: core/macrocell_defines.svh
`ifndef MACROCELL_DEFINES_SVH
`define MACROCELL_DEFINES_SVH

// register byte offsets
`define OFS_CTRL        5'h00
`define OFS_TERMSEL     5'h04
`define OFS_PTADDR      5'h08
`define OFS_PTDATA      5'h0C
`define OFS_MATRIX      5'h10
`define OFS_STATUS      5'h14

// control register fields
`define CTRL_SUM_LSB    0
`define CTRL_CASC_BIT   5
`define CTRL_XOR_LSB    6
`define CTRL_DATA_LSB   8
`define CTRL_MODE_LSB   10
`define CTRL_CLK_BIT    13
`define CTRL_CE_BIT     14
`define CTRL_CLR_LSB    15
`define CTRL_PRE_BIT    17
`define CTRL_OREG_BIT   18
`define CTRL_FREG_BIT   19
`define CTRL_IO_LSB     20
`define CTRL_OE_LSB     22
`define CTRL_KEEP_BIT   25
`define CTRL_PD_BIT     26
`define CTRL_OC_BIT     27

// term index register fields, three bits each
`define TSEL_XOR_LSB    0
`define TSEL_DATA_LSB   3
`define TSEL_CLK_LSB    6
`define TSEL_CE_LSB     9
`define TSEL_CLR_LSB    12
`define TSEL_PRE_LSB    15
`define TSEL_FOLD_LSB   18
`define TSEL_OE_LSB     21

// term window address fields
`define PTADDR_TERM_LSB 0
`define PTADDR_CMP_BIT  3
`define PTADDR_HI_BIT   4

// switch matrix access fields
`define MATRIX_SRC_LSB  0
`define MATRIX_SLOT_LSB 16

// status bits
`define STAT_Q_BIT      0
`define STAT_PD_BIT     1
`define STAT_SUM_BIT    2
`define STAT_OUT_BIT    3
`define STAT_PIN_BIT    4

// reset values
`define CTRL_RST        32'h0000_0000
`define TSEL_RST        32'h0000_0000
`define PTADDR_RST      5'h00
`define WAIT_RST        1'b1

`endif

// file: core/macrocell_pkg.sv
package macrocell_pkg;

	typedef enum logic [1:0] {XOR_TERM = 2'h0, XOR_HIGH = 2'h1, XOR_LOW = 2'h2} xor_sel_t;
	typedef enum logic [1:0] {DATA_XOR = 2'h0, DATA_TERM = 2'h1, DATA_PIN = 2'h2} data_sel_t;
	typedef enum logic [2:0] {
		MODE_D = 3'h0, MODE_T = 3'h1, MODE_JK = 3'h2, MODE_SR = 3'h3, MODE_LATCH = 3'h4
	} ff_mode_t;
	typedef enum logic [1:0] {
		CLR_OFF = 2'h0, CLR_GLOBAL = 2'h1, CLR_TERM = 2'h2, CLR_BOTH = 2'h3
	} clr_sel_t;
	typedef enum logic [1:0] {IO_INPUT = 2'h0, IO_OUTPUT = 2'h1, IO_BIDIR = 2'h2} io_mode_t;
	typedef enum logic [2:0] {
		OE_PIN_A = 3'h0, OE_PIN_A_N = 3'h1, OE_PIN_B = 3'h2, OE_PIN_B_N = 3'h3,
		OE_PIN_SUB = 3'h4, OE_CELL_SUB = 3'h5
	} oe_sel_t;

endpackage : macrocell_pkg

// file: core/configurable_logic_macrocell.sv
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "macrocell_defines.svh"

// What this block does
// - five terms, each over global and regional inputs
// - selector gives each term to sum or control
// - OR sums terms plus chained neighbour sum
// - XOR second input: term, high or low
// - XOR sets polarity, emulates T and JK
// - data from XOR, own term or pin
// - D, T, JK, SR and transparent latch modes
// - clock from global pin or term, rising edge
// - low clock-enable term ignores global clock edges
// - clear: global pin, term, both or off
// - preset: term or off
// - output and feedback each registered or combinatorial
// - pin input, output or bidir; enable selectable
// - input-only pin keeps full cell logic
// - matrix picks up to 40 global signals
// - inverted term goes to regional foldback bus
// - keeper holds last driven pin level
// - power-down latches internal state and outputs
// - pin changes ignored while powered down
// - power-down pins are not logic inputs
// - reset initialises every register, outputs released
module configurable_logic_macrocell
	import macrocell_pkg::*;
#(
	parameter int GLOBAL_W = 228,
	parameter int MATRIX_N = 40,
	parameter int REGION_N = 16,
	parameter int OE_SUB_N = 8
) (
	input  wire logic                ref_clk,        // system clock
	input  wire logic                rst_n,          // asynchronous reset
	input  wire logic [4:0]          address,        // byte address
	input  wire logic                read,           // read request
	input  wire logic                write,          // write request
	input  wire logic [31:0]         writedata,      // write data
	input  wire logic [3:0]          byteenable,     // write byte lanes
	output logic      [31:0]         readdata,       // read data
	output logic                     waitrequest,    // slave stall
	input  wire logic [GLOBAL_W-1:0] globalBus,      // pins and cell feedbacks
	input  wire logic [REGION_N-1:0] regionalBus,    // foldback terms of region
	input  wire logic                chainIn,        // chained sum input
	input  wire logic                globalClockPin, // global clock pin
	input  wire logic                globalClearPin, // global clear pin
	input  wire logic                oeEnPinA,       // enable pin a
	input  wire logic                oeEnPinB,       // enable pin b
	input  wire logic [OE_SUB_N-1:0] oePinSubset,    // enable candidates from pins
	input  wire logic [OE_SUB_N-1:0] oeCellSubset,   // enable candidates from cells
	input  wire logic                ioPinIn,        // pin level seen
	input  wire logic                ioExtDrive,     // someone outside drives pin
	input  wire logic                powerDownPinA,  // power-down pin a
	input  wire logic                powerDownPinB,  // power-down pin b
	output logic                     ioOut,          // pin output value
	output logic                     ioOe,           // pin output enable
	output logic                     feedback,       // buried feedback
	output logic                     foldback,       // regional foldback term
	output logic                     chainOut        // sum to next cell
);

	localparam int ARRAY_W = MATRIX_N + REGION_N;
	localparam int SEL_W   = $clog2(GLOBAL_W);
	localparam int SLOT_W  = $clog2(MATRIX_N);
	localparam int PIN_W   = GLOBAL_W + OE_SUB_N + 6;

	function automatic logic termEval(input logic [ARRAY_W-1:0] in,
		input logic [ARRAY_W-1:0] tru, input logic [ARRAY_W-1:0] cmp);
		return (&(in | ~tru)) && (&(~in | ~cmp));
	endfunction : termEval

	function automatic logic termAt(input logic [4:0] vec, input logic [2:0] idx);
		return (idx < 3'h5) ? vec[idx] : 1'b0;
	endfunction : termAt

	function automatic logic [4:0] bitOf(input logic [2:0] idx);
		return (idx < 3'h5) ? (5'h01 << idx) : 5'h00;
	endfunction : bitOf

	function automatic logic [31:0] applyBe(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) res[8*b +: 8] = data[8*b +: 8];
		end
		return res;
	endfunction : applyBe

	function automatic logic [ARRAY_W-1:0] putWord(input logic [ARRAY_W-1:0] old,
		input logic hi, input logic [31:0] data, input logic [3:0] be);
		logic [63:0] wide;
		wide = 64'(old);
		wide[(hi ? 32 : 0) +: 32] = applyBe(wide[(hi ? 32 : 0) +: 32], data, be);
		return wide[ARRAY_W-1:0];
	endfunction : putWord

	// terms taken by a control input drop out of the sum
	function automatic logic [4:0] claims(input logic [31:0] c, input logic [31:0] t);
		logic [4:0] m;
		m = 5'h00;
		if (c[`CTRL_XOR_LSB +: 2] == XOR_TERM || c[`CTRL_MODE_LSB +: 3] == MODE_JK ||
			c[`CTRL_MODE_LSB +: 3] == MODE_SR) m = m | bitOf(t[`TSEL_XOR_LSB +: 3]);
		if (c[`CTRL_DATA_LSB +: 2] == DATA_TERM) m = m | bitOf(t[`TSEL_DATA_LSB +: 3]);
		if (c[`CTRL_CLK_BIT]) m = m | bitOf(t[`TSEL_CLK_LSB +: 3]);
		if (c[`CTRL_CE_BIT] && !c[`CTRL_CLK_BIT]) m = m | bitOf(t[`TSEL_CE_LSB +: 3]);
		if (c[`CTRL_CLR_LSB + 1]) m = m | bitOf(t[`TSEL_CLR_LSB +: 3]);
		if (c[`CTRL_PRE_BIT]) m = m | bitOf(t[`TSEL_PRE_LSB +: 3]);
		return m;
	endfunction : claims

	logic [1:0]          rstPipe;
	logic                rstSync;
	logic [PIN_W-1:0]    pinRaw;
	logic [PIN_W-1:0]    pinMeta;
	logic [PIN_W-1:0]    pinSync;
	logic [PIN_W-1:0]    pinView;
	logic [1:0]          pdMeta;
	logic [1:0]          pdSync;
	logic                pdActive;
	logic [31:0]         ctrl;
	logic [31:0]         termSel;
	logic [4:0]          ptAddr;
	logic [SLOT_W-1:0]   matrixSlot;
	logic [SEL_W-1:0]    matrixSel [MATRIX_N];
	logic [ARRAY_W-1:0]  ptTrue [5];
	logic [ARRAY_W-1:0]  ptComp [5];
	logic [31:0]         readMux;
	logic                writeHit;
	logic [GLOBAL_W-1:0] gBus;
	logic [OE_SUB_N-1:0] pinSub;
	logic                ioPinV;
	logic                extDriveV;
	logic                global_clock_pin;
	logic                gclr;
	logic                oeA;
	logic                oeB;
	logic [ARRAY_W-1:0]  arrayIn;
	logic [4:0]          ptVec;
	logic [4:0]          sumTerms;
	logic                sumOr;
	logic                xorIn;
	logic                xorOut;
	logic                dataIn;
	logic                elemClk;
	logic                clkPrev;
	logic                clkRise;
	logic                ceOk;
	logic                clrActive;
	logic                preActive;
	logic                nextState;
	logic                q;
	logic                outVal;
	logic                oeSelected;
	logic                next_ioOe;
	logic                keptLevel;
	logic                pinLevel;
	xor_sel_t            xorSel;
	data_sel_t           dataSel;
	ff_mode_t            ffMode;
	clr_sel_t            clrSel;
	io_mode_t            ioMode;
	oe_sel_t             oeSel;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) rstPipe <= 2'h0;
		else rstPipe <= {rstPipe[0], 1'b1};
	end
	assign rstSync = rstPipe[1];

	// power-down pins feed only the power-down detector
	always_ff @(posedge ref_clk or negedge rstSync) begin
		if (!rstSync) begin
			pdMeta   <= 2'h0;
			pdSync   <= 2'h0;
			pdActive <= 1'b0;
		end else begin
			pdMeta   <= {powerDownPinB, powerDownPinA};
			pdSync   <= pdMeta;
			pdActive <= ctrl[`CTRL_PD_BIT] && (|pdSync);
		end
	end

	assign pinRaw = {globalBus, oePinSubset, ioPinIn, ioExtDrive, globalClockPin,
		globalClearPin, oeEnPinA, oeEnPinB};

	// the held view is what makes the cell deaf to pins while powered down
	always_ff @(posedge ref_clk or negedge rstSync) begin
		if (!rstSync) begin
			pinMeta <= '0;
			pinSync <= '0;
			pinView <= '0;
		end else begin
			pinMeta <= pinRaw;
			pinSync <= pinMeta;
			if (!pdActive) pinView <= pinSync;
		end
	end

	assign gBus      = pinView[PIN_W-1 -: GLOBAL_W];
	assign pinSub    = pinView[OE_SUB_N+5:6];
	assign ioPinV    = pinView[5];
	assign extDriveV = pinView[4];
	assign global_clock_pin       = pinView[3];
	assign gclr      = pinView[2];
	assign oeA       = pinView[1];
	assign oeB       = pinView[0];

	// bus slave: one wait cycle, then a single ready cycle
	assign writeHit = write && !waitrequest;

	always_ff @(posedge ref_clk or negedge rstSync) begin
		if (!rstSync) waitrequest <= `WAIT_RST;
		else waitrequest <= !((read || write) && waitrequest);
	end

	always_ff @(posedge ref_clk or negedge rstSync) begin
		if (!rstSync) readdata <= 32'h0000_0000;
		else if (read && waitrequest) readdata <= readMux;
	end

	always_comb begin
		readMux = 32'h0000_0000;
		case (address)
			`OFS_CTRL:    readMux = ctrl;
			`OFS_TERMSEL: readMux = termSel;
			`OFS_PTADDR:  readMux = 32'(ptAddr);
			`OFS_PTDATA: begin
				if (ptAddr[`PTADDR_TERM_LSB +: 3] < 3'h5)
					readMux = 32'((ptAddr[`PTADDR_CMP_BIT] ?
						64'(ptComp[ptAddr[`PTADDR_TERM_LSB +: 3]]) :
						64'(ptTrue[ptAddr[`PTADDR_TERM_LSB +: 3]])) >>
						(ptAddr[`PTADDR_HI_BIT] ? 32 : 0));
			end
			`OFS_MATRIX: begin
				readMux[`MATRIX_SLOT_LSB +: SLOT_W] = matrixSlot;
				// a slot past the matrix has no source; read it as zero, not unknown
				if (int'(matrixSlot) < MATRIX_N)
					readMux[`MATRIX_SRC_LSB +: SEL_W] = matrixSel[matrixSlot];
			end
			`OFS_STATUS: begin
				readMux[`STAT_Q_BIT]   = q;
				readMux[`STAT_PD_BIT]  = pdActive;
				readMux[`STAT_SUM_BIT] = sumOr;
				readMux[`STAT_OUT_BIT] = ioOut;
				readMux[`STAT_PIN_BIT] = pinLevel;
			end
			default: readMux = 32'h0000_0000;
		endcase
	end

	// software loads the selections once; they are not meant to move in operation
	always_ff @(posedge ref_clk or negedge rstSync) begin
		if (!rstSync) begin
			ctrl       <= `CTRL_RST;
			termSel    <= `TSEL_RST;
			ptAddr     <= `PTADDR_RST;
			matrixSlot <= '0;
		end else if (writeHit) begin
			case (address)
				`OFS_CTRL:    ctrl <= applyBe(ctrl, writedata, byteenable);
				`OFS_TERMSEL: termSel <= applyBe(termSel, writedata, byteenable);
				`OFS_PTADDR:  ptAddr <= writedata[4:0];
				`OFS_MATRIX:  matrixSlot <= writedata[`MATRIX_SLOT_LSB +: SLOT_W];
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstSync) begin
		if (!rstSync) begin
			for (int i = 0; i < 5; i++) begin
				ptTrue[i] <= '0;
				ptComp[i] <= '0;
			end
			for (int i = 0; i < MATRIX_N; i++) matrixSel[i] <= '0;
		end else if (writeHit) begin
			if (address == `OFS_PTDATA && ptAddr[`PTADDR_TERM_LSB +: 3] < 3'h5) begin
				if (ptAddr[`PTADDR_CMP_BIT])
					ptComp[ptAddr[2:0]] <= putWord(ptComp[ptAddr[2:0]],
						ptAddr[`PTADDR_HI_BIT], writedata, byteenable);
				else
					ptTrue[ptAddr[2:0]] <= putWord(ptTrue[ptAddr[2:0]],
						ptAddr[`PTADDR_HI_BIT], writedata, byteenable);
			end
			if (address == `OFS_MATRIX && int'(writedata[`MATRIX_SLOT_LSB +: SLOT_W]) < MATRIX_N)
				matrixSel[writedata[`MATRIX_SLOT_LSB +: SLOT_W]] <=
					writedata[`MATRIX_SRC_LSB +: SEL_W];
		end
	end

	assign xorSel  = xor_sel_t'(ctrl[`CTRL_XOR_LSB +: 2]);
	assign dataSel = data_sel_t'(ctrl[`CTRL_DATA_LSB +: 2]);
	assign ffMode  = ff_mode_t'(ctrl[`CTRL_MODE_LSB +: 3]);
	assign clrSel  = clr_sel_t'(ctrl[`CTRL_CLR_LSB +: 2]);
	assign ioMode  = io_mode_t'(ctrl[`CTRL_IO_LSB +: 2]);
	assign oeSel   = oe_sel_t'(ctrl[`CTRL_OE_LSB +: 3]);

	always_comb begin
		for (int i = 0; i < MATRIX_N; i++)
			arrayIn[i] = (int'(matrixSel[i]) < GLOBAL_W) ? gBus[matrixSel[i]] : 1'b0;
		arrayIn[ARRAY_W-1:MATRIX_N] = regionalBus;
		for (int i = 0; i < 5; i++)
			ptVec[i] = termEval(arrayIn, ptTrue[i], ptComp[i]);
	end

	assign sumTerms = ptVec & ctrl[`CTRL_SUM_LSB +: 5] & ~claims(ctrl, termSel);
	assign sumOr    = (|sumTerms) || (ctrl[`CTRL_CASC_BIT] && chainIn);

	always_comb begin
		case (xorSel)
			XOR_TERM: xorIn = termAt(ptVec, termSel[`TSEL_XOR_LSB +: 3]);
			XOR_HIGH: xorIn = 1'b1;
			default:  xorIn = 1'b0;
		endcase
	end
	assign xorOut = sumOr ^ xorIn;

	always_comb begin
		case (dataSel)
			DATA_TERM: dataIn = termAt(ptVec, termSel[`TSEL_DATA_LSB +: 3]);
			DATA_PIN:  dataIn = pinLevel;
			default:   dataIn = xorOut;
		endcase
	end

	assign elemClk = ctrl[`CTRL_CLK_BIT] ? termAt(ptVec, termSel[`TSEL_CLK_LSB +: 3]) : global_clock_pin;
	assign clkRise = elemClk && !clkPrev;
	assign ceOk    = ctrl[`CTRL_CLK_BIT] || !ctrl[`CTRL_CE_BIT] ||
		termAt(ptVec, termSel[`TSEL_CE_LSB +: 3]);

	always_comb begin
		case (clrSel)
			CLR_GLOBAL: clrActive = gclr;
			CLR_TERM:   clrActive = termAt(ptVec, termSel[`TSEL_CLR_LSB +: 3]);
			CLR_BOTH:   clrActive = gclr || termAt(ptVec, termSel[`TSEL_CLR_LSB +: 3]);
			default:    clrActive = 1'b0;
		endcase
	end
	assign preActive = ctrl[`CTRL_PRE_BIT] && termAt(ptVec, termSel[`TSEL_PRE_LSB +: 3]);

	// JK and SR take the sum as J/S and the XOR term as K/R
	always_comb begin
		case (ffMode)
			MODE_T:  nextState = q ^ dataIn;
			MODE_JK: nextState = (sumOr && !q) ||
				(!termAt(ptVec, termSel[`TSEL_XOR_LSB +: 3]) && q);
			MODE_SR: nextState = sumOr ? 1'b1 :
				(termAt(ptVec, termSel[`TSEL_XOR_LSB +: 3]) ? 1'b0 : q);
			default: nextState = dataIn;
		endcase
	end

	// clear and preset act on level, independent of the element clock
	always_ff @(posedge ref_clk or negedge rstSync) begin
		if (!rstSync) begin
			q       <= 1'b0;
			clkPrev <= 1'b0;
		end else if (!pdActive) begin
			clkPrev <= elemClk;
			if (clrActive) q <= 1'b0;
			else if (preActive) q <= 1'b1;
			else if (ffMode == MODE_LATCH) begin
				if (elemClk) q <= dataIn;
			end else if (clkRise && ceOk) q <= nextState;
		end
	end

	assign outVal = ctrl[`CTRL_OREG_BIT] ? q : xorOut;

	always_comb begin
		case (oeSel)
			OE_PIN_A:    oeSelected = oeA;
			OE_PIN_A_N:  oeSelected = !oeA;
			OE_PIN_B:    oeSelected = oeB;
			OE_PIN_B_N:  oeSelected = !oeB;
			OE_PIN_SUB:  oeSelected = (int'(termSel[`TSEL_OE_LSB +: 3]) < OE_SUB_N) &&
				pinSub[termSel[`TSEL_OE_LSB +: 3]];
			OE_CELL_SUB: oeSelected = (int'(termSel[`TSEL_OE_LSB +: 3]) < OE_SUB_N) &&
				oeCellSubset[termSel[`TSEL_OE_LSB +: 3]];
			default:     oeSelected = 1'b0;
		endcase
	end

	always_comb begin
		case (ioMode)
			IO_OUTPUT: next_ioOe = 1'b1;
			IO_BIDIR:  next_ioOe = oeSelected;
			default:   next_ioOe = 1'b0;
		endcase
	end

	// feedback, foldback and chain keep running whatever the pin mode
	always_ff @(posedge ref_clk or negedge rstSync) begin
		if (!rstSync) begin
			ioOut    <= 1'b0;
			ioOe     <= 1'b0;
			feedback <= 1'b0;
			foldback <= 1'b0;
			chainOut <= 1'b0;
		end else if (!pdActive) begin
			feedback <= ctrl[`CTRL_FREG_BIT] ? q : xorOut;
			foldback <= !termAt(ptVec, termSel[`TSEL_FOLD_LSB +: 3]);
			chainOut <= sumOr;
			ioOut    <= ctrl[`CTRL_OC_BIT] ? 1'b0 : outVal;
			ioOe     <= ctrl[`CTRL_OC_BIT] ? (next_ioOe && !outVal) : next_ioOe;
		end
	end

	// keeper trades an extra flop for a defined level on a floating pin
	always_ff @(posedge ref_clk or negedge rstSync) begin
		if (!rstSync) keptLevel <= 1'b0;
		else if (!pdActive && (ioOe || extDriveV)) keptLevel <= ioOe ? ioOut : ioPinV;
	end

	assign pinLevel = ioOe ? ioOut : extDriveV ? ioPinV :
		(ctrl[`CTRL_KEEP_BIT] ? keptLevel : 1'b0);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstSync);

	sequence busAsk;
		(read || write) && waitrequest;
	endsequence
	sequence ackPulse;
		!waitrequest ##1 waitrequest;
	endsequence
	sequence dEdge;
		ffMode == MODE_D && clkRise && ceOk && !clrActive && !preActive && !pdActive;
	endsequence

	bus_answer_a: assert property (busAsk |=> ackPulse)
		else $error("bus answer not one wait cycle");
	pd_hold_a: assert property (pdActive |=> $stable(ioOut) && $stable(ioOe) && $stable(q))
		else $error("state moved during power-down");
	pin_ignore_a: assert property (pdActive |=> $stable(pinView))
		else $error("pin view moved during power-down");
	clear_wins_a: assert property (clrActive && !pdActive |=> !q)
		else $error("clear did not clear");
	preset_sets_a: assert property (preActive && !clrActive && !pdActive |=> q)
		else $error("preset did not set");
	ce_block_a: assert property (clkRise && !ctrl[`CTRL_CLK_BIT] && !ceOk && !clrActive &&
		!preActive && ffMode != MODE_LATCH && !pdActive |=> $stable(q))
		else $error("disabled edge changed state");
	latch_follow_a: assert property (ffMode == MODE_LATCH && elemClk && !clrActive &&
		!preActive && !pdActive |=> q == $past(dataIn))
		else $error("latch did not follow data");
	d_edge_a: assert property (dEdge |=> q == $past(dataIn))
		else $error("d edge did not load data");
	input_only_a: assert property (ioMode == IO_INPUT && !pdActive |=> !ioOe)
		else $error("input pin enabled");
	oc_low_a: assert property ($past(ctrl[`CTRL_OC_BIT]) && !$past(pdActive) && ioOe |-> !ioOut)
		else $error("open collector drove high");
	fold_inv_a: assert property (!pdActive |=>
		foldback == !$past(termAt(ptVec, termSel[`TSEL_FOLD_LSB +: 3])))
		else $error("foldback not inverted term");

endmodule : configurable_logic_macrocell

// file: testbench/board_model.sv
`timescale 1ns/1ps
module board_model (
	input  wire logic ref_clk,   // system clock
	input  wire logic drive,     // board drives the pin
	input  wire logic level,     // level driven by board
	output logic      ioPinIn,   // pin level at device
	output logic      ioExtDrive // board drive flag
);
	// a released pin floats: a moving level exposes a missing keeper
	initial begin
		ioPinIn = 1'h0;
		ioExtDrive = 1'h0;
	end
	always @(posedge ref_clk) begin
		ioPinIn <= drive ? level : ~ioPinIn;
		ioExtDrive <= drive;
	end
endmodule : board_model

// file: testbench/configurable_logic_macrocell_bench.sv
`timescale 1ns/1ps
`include "macrocell_defines.svh"
module configurable_logic_macrocell_bench;
	logic         ref_clk = 1'h0;
	logic         rst_n = 1'h0;
	logic [4:0]   address = 5'h00;
	logic         read = 1'h0;
	logic         write = 1'h0;
	logic [31:0]  writedata = 32'h0;
	logic [3:0]   byteEn = 4'hF;
	logic [31:0]  readdata;
	logic [31:0]  v;
	logic         waitrequest;
	logic [227:0] globalBus = '0;
	logic [15:0]  region = 16'h0;
	logic [7:0]   oeSub = 8'h0;
	logic         chn = 1'h0;
	logic         global_clock_pin = 1'h0;
	logic         gclr = 1'h0;
	logic         pdA = 1'h0;
	logic         pdB = 1'h0;
	logic         oeA = 1'h0;
	logic         oeB = 1'h0;
	logic         drv = 1'h0;
	logic         lvl = 1'h0;
	logic         ioPinIn, ioExtDrive, ioOut, ioOe, feedback, fold, chnOut;
	int           num_errors = 0;
	int           check_count = 0;

	initial forever #12.5 ref_clk = ~ref_clk;

	configurable_logic_macrocell configurable_logic_macrocell_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteEn),
		.readdata(readdata), .waitrequest(waitrequest), .globalBus(globalBus),
		.regionalBus(region), .chainIn(chn), .globalClockPin(global_clock_pin),
		.globalClearPin(gclr), .oeEnPinA(oeA), .oeEnPinB(oeB),
		.oePinSubset(oeSub), .oeCellSubset(oeSub), .ioPinIn(ioPinIn),
		.ioExtDrive(ioExtDrive), .powerDownPinA(pdA), .powerDownPinB(pdB),
		.ioOut(ioOut), .ioOe(ioOe), .feedback(feedback), .foldback(fold),
		.chainOut(chnOut)
	);

	board_model board_model_i (
		.ref_clk(ref_clk), .drive(drv), .level(lvl),
		.ioPinIn(ioPinIn), .ioExtDrive(ioExtDrive)
	);

	task complete_run;
		$display("Errors %0d of %0d checks", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("Error %0t: got %h want %h", $time, got, exp);
			num_errors++;
		end
	endtask : chk

	// one access; entered just after a rising edge, leaves three edges later
	task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		address <= a;
		writedata <= d;
		write <= w;
		read <= ~w;
		@(posedge ref_clk);
		while (waitrequest !== 1'h0) begin
			n++;
			if (n > 20) begin
				num_errors++;
				complete_run();
			end
			@(posedge ref_clk);
		end
		v = readdata;
		write <= 1'h0;
		read <= 1'h0;
		@(posedge ref_clk);
	endtask : acc

	// pins pass two sync flops and a view flop before the output flop
	task settle;
		repeat (6) @(posedge ref_clk);
	endtask : settle

	task st(input int b, input logic e);
		settle();
		acc(1'h0, `OFS_STATUS, 32'h0);
		chk(32'(v[b]), 32'(e));
	endtask : st

	task pulse;
		global_clock_pin <= 1'h1;
		settle();
		global_clock_pin <= 1'h0;
		settle();
	endtask : pulse

	initial begin
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge ref_clk);
		acc(1'h0, `OFS_CTRL, 32'h0);
		chk(v, `CTRL_RST);
		acc(1'h0, `OFS_TERMSEL, 32'h0);
		chk(v, `TSEL_RST);
		acc(1'h0, 5'h1C, 32'h0);
		chk(v, 32'h0);
		acc(1'h1, `OFS_CTRL, 32'h0010_0041);
		settle();
		chk(32'(ioOe), 32'h1);
		chk(32'(ioOut), 32'h0);
		acc(1'h1, `OFS_CTRL, 32'h0010_0081);
		settle();
		chk(32'(ioOut), 32'h1);
		acc(1'h1, `OFS_CTRL, 32'h0010_00A0);
		chn <= 1'h1;
		st(2, 1'h1);
		chn <= 1'h0;
		st(2, 1'h0);
		acc(1'h1, `OFS_PTADDR, 32'h0);
		acc(1'h1, `OFS_PTDATA, 32'h1);
		acc(1'h0, `OFS_PTDATA, 32'h0);
		chk(v, 32'h1);
		acc(1'h1, `OFS_MATRIX, 32'h0000_0005);
		acc(1'h0, `OFS_MATRIX, 32'h0);
		chk(v, 32'h0000_0005);
		acc(1'h1, `OFS_CTRL, 32'h0010_0081);
		st(2, 1'h0);
		globalBus[5] <= 1'h1;
		st(2, 1'h1);
		acc(1'h1, `OFS_CTRL, 32'h0014_0081);
		pulse();
		st(0, 1'h1);
		chk(32'(ioOut), 32'h1);
		globalBus[5] <= 1'h0;
		st(0, 1'h1);
		pulse();
		st(0, 1'h0);
		acc(1'h1, `OFS_CTRL, 32'h0014_8081);
		globalBus[5] <= 1'h1;
		gclr <= 1'h1;
		pulse();
		st(0, 1'h0);
		gclr <= 1'h0;
		pulse();
		st(0, 1'h1);
		acc(1'h1, `OFS_CTRL, 32'h0414_0081);
		pdA <= 1'h1;
		st(1, 1'h1);
		globalBus[5] <= 1'h0;
		pulse();
		st(0, 1'h1);
		pdA <= 1'h0;
		st(1, 1'h0);
		pulse();
		st(0, 1'h0);
		pdB <= 1'h1;
		st(1, 1'h1);
		pdB <= 1'h0;
		st(1, 1'h0);
		acc(1'h1, `OFS_CTRL, 32'h0810_0041);
		settle();
		chk(32'(ioOe), 32'h0);
		acc(1'h1, `OFS_CTRL, 32'h0810_0081);
		settle();
		chk(32'(ioOe), 32'h1);
		chk(32'(ioOut), 32'h0);
		chk(32'(fold), 32'h1);
		chk(32'(chnOut), 32'h0);
		acc(1'h1, `OFS_CTRL, 32'h0000_0081);
		globalBus[5] <= 1'h1;
		settle();
		chk(32'(feedback), 32'h1);
		chk(32'(ioOe), 32'h0);
		chk(32'(fold), 32'h0);
		chk(32'(chnOut), 32'h1);
		acc(1'h1, `OFS_CTRL, 32'h0000_1081);
		global_clock_pin <= 1'h1;
		st(0, 1'h1);
		globalBus[5] <= 1'h0;
		st(0, 1'h0);
		global_clock_pin <= 1'h0;
		globalBus[5] <= 1'h1;
		st(0, 1'h0);
		acc(1'h1, `OFS_CTRL, 32'h0002_0080);
		st(0, 1'h1);
		acc(1'h1, `OFS_CTRL, 32'h0000_4080);
		globalBus[5] <= 1'h0;
		pulse();
		st(0, 1'h1);
		globalBus[5] <= 1'h1;
		pulse();
		st(0, 1'h0);
		acc(1'h1, `OFS_CTRL, 32'h0000_0481);
		pulse();
		st(0, 1'h1);
		pulse();
		st(0, 1'h0);
		acc(1'h1, `OFS_TERMSEL, 32'h0000_0008);
		acc(1'h1, `OFS_CTRL, 32'h0000_0141);
		pulse();
		st(0, 1'h1);
		acc(1'h1, `OFS_TERMSEL, 32'h0000_0001);
		acc(1'h1, `OFS_CTRL, 32'h0000_0C01);
		globalBus[5] <= 1'h0;
		pulse();
		st(0, 1'h0);
		acc(1'h1, `OFS_CTRL, 32'h0000_0801);
		globalBus[5] <= 1'h1;
		pulse();
		st(0, 1'h1);
		pulse();
		st(0, 1'h0);
		acc(1'h1, `OFS_CTRL, 32'h0020_0000);
		oeA <= 1'h1;
		settle();
		chk(32'(ioOe), 32'h1);
		oeA <= 1'h0;
		settle();
		chk(32'(ioOe), 32'h0);
		acc(1'h1, `OFS_CTRL, 32'h00E0_0000);
		settle();
		chk(32'(ioOe), 32'h1);
		acc(1'h1, `OFS_CTRL, 32'h0200_0000);
		drv <= 1'h1;
		lvl <= 1'h1;
		st(4, 1'h1);
		drv <= 1'h0;
		st(4, 1'h1);
		drv <= 1'h1;
		lvl <= 1'h0;
		st(4, 1'h0);
		drv <= 1'h0;
		st(4, 1'h0);
		acc(1'h1, `OFS_CTRL, 32'h0);
		drv <= 1'h1;
		lvl <= 1'h1;
		st(4, 1'h1);
		drv <= 1'h0;
		st(4, 1'h0);
		complete_run();
	end
endmodule : configurable_logic_macrocell_bench
